//--- design/flash_ctrl_map.vh
// Purpose: Register offsets, bit positions and reset values of the flash
//          program/erase control block.
// Assumes: 16-bit byte address, 8-bit data.
// Notes:   Definitions only.
`ifndef FLASH_CTRL_MAP_VH
`define FLASH_CTRL_MAP_VH

// ****************************************************************
// Offsets
// ****************************************************************
`define FLASH_CONTROL_ONE_ADDR     16'hf020
`define FLASH_CONTROL_TWO_ADDR     16'hf021
`define FLASH_POWER_CONTROL_ADDR   16'hf022
`define ERASE_BLOCK_SELECT_ADDR    16'hf023
`define FLASH_ACCESS_ENABLE_ADDR   16'hf02b

// ****************************************************************
// Fields of the first control register
// ****************************************************************
`define SW_WRITE_ENABLE_BIT        6
`define ERASE_SETUP_BIT            5
`define PROGRAM_SETUP_BIT          4
`define ERASE_VERIFY_BIT           3
`define PROGRAM_VERIFY_BIT         2
`define ERASE_BIT                  1
`define PROGRAM_BIT                0

// ****************************************************************
// Single-bit fields of the other registers
// ****************************************************************
`define FLASH_ERROR_FLAG_BIT       7
`define POWER_DOWN_DISABLE_BIT     7
`define ACCESS_ENABLE_BIT          7

// ****************************************************************
// Reset values
// ****************************************************************
`define REG_RESET_VALUE            8'h00

`endif

//--- design/flash_program_erase_control.v
// Purpose: Control registers for flash program and erase sequencing.
// Assumes: One clock, plain register port with read data one cycle later.
// Notes:   Mode bits leave the block as registered levels.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "flash_ctrl_map.vh"

// Functional notes
// - Program bit sets only with write enable and program setup both 1.
// - Erase bit sets only with write enable and erase setup both 1.
// - Program-verify bit sets only while write enable is 1.
// - Erase-verify bit sets only while write enable is 1.
// - Program setup takes effect only while write enable is 1.
// - Erase setup takes effect only while write enable is 1.
// - Write enable 0 at reset blocks writing and erasing; 1 allows.
// - All mode and setup bits of control one reset to 0.
// - Power-down disable 0 lets flash sleep in sub-active mode.
// - Eight erase block bits select blocks when 1, reset 0.
// - Access enable 0 at reset hides control registers; 1 opens.
module flash_program_erase_control (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [15:0] addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  input  wire        flash_error_in,
  input  wire        sub_active_in,
  output reg  [7:0]  rdata_out,
  output reg         sw_write_enable_out,
  output reg         program_mode_out,
  output reg         erase_mode_out,
  output reg         program_verify_out,
  output reg         erase_verify_out,
  output reg         program_setup_out,
  output reg         erase_setup_out,
  output reg  [7:0]  erase_block_out,
  output reg         flash_low_power_out
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Fields of control one, one flop each
  reg        sw_write_enable_q;
  reg        sw_write_enable_d;
  reg        erase_setup_q;
  reg        erase_setup_d;
  reg        program_setup_q;
  reg        program_setup_d;
  reg        erase_verify_q;
  reg        erase_verify_d;
  reg        program_verify_q;
  reg        program_verify_d;
  reg        erase_q;
  reg        erase_d;
  reg        program_q;
  reg        program_d;
  // Other registers
  reg        error_flag_q;
  reg        power_down_disable_q;
  reg        power_down_disable_d;
  reg  [7:0] erase_block_q;
  wire [7:0] erase_block_d;
  reg        access_enable_q;
  reg        access_enable_d;
  reg        low_power_d;
  // Two flops per pin from outside the clock domain, against metastability
  reg        err_sync1_q;
  reg        err_sync2_q;
  reg        sub_sync1_q;
  reg        sub_sync2_q;
  // Read path
  reg  [7:0] rdata_d;
  reg  [7:0] ctrl_one_view;
  reg  [7:0] ctrl_two_view;
  reg  [7:0] power_view;
  reg  [7:0] enable_view;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire       sel_one;
  wire       sel_two;
  wire       sel_pwr;
  wire       sel_block;
  wire       sel_en;
  wire       wr_ok;
  wire       wr_one;
  wire       wr_pwr;
  wire       wr_block;
  wire       wr_en;

  assign sel_one   = (addr_in == `FLASH_CONTROL_ONE_ADDR);
  assign sel_two   = (addr_in == `FLASH_CONTROL_TWO_ADDR);
  assign sel_pwr   = (addr_in == `FLASH_POWER_CONTROL_ADDR);
  assign sel_block = (addr_in == `ERASE_BLOCK_SELECT_ADDR);
  assign sel_en    = (addr_in == `FLASH_ACCESS_ENABLE_ADDR);

  assign wr_ok     = wr_in & access_enable_q;
  assign wr_one    = wr_ok & sel_one;
  assign wr_pwr    = wr_ok & sel_pwr;
  assign wr_block  = wr_ok & sel_block;
  assign wr_en     = wr_in & sel_en;

  // ****************************************************************
  // Next value of control one
  // ****************************************************************
  always @* begin
    sw_write_enable_d = sw_write_enable_q;
    erase_setup_d     = erase_setup_q;
    program_setup_d   = program_setup_q;
    erase_verify_d    = erase_verify_q;
    program_verify_d  = program_verify_q;
    erase_d           = erase_q;
    program_d         = program_q;
    if (wr_one) begin
      sw_write_enable_d = wdata_in[`SW_WRITE_ENABLE_BIT];
      erase_setup_d     = 1'b0;
      program_setup_d   = 1'b0;
      erase_verify_d    = 1'b0;
      program_verify_d  = 1'b0;
      erase_d           = 1'b0;
      program_d         = 1'b0;
      if (wdata_in[`SW_WRITE_ENABLE_BIT]) begin
        program_setup_d  = wdata_in[`PROGRAM_SETUP_BIT];
        erase_setup_d    = wdata_in[`ERASE_SETUP_BIT];
        program_verify_d = wdata_in[`PROGRAM_VERIFY_BIT];
        erase_verify_d   = wdata_in[`ERASE_VERIFY_BIT];
        // setup must already be stored, so one write cannot do both
        program_d        = wdata_in[`PROGRAM_BIT] & program_setup_q;
        erase_d          = wdata_in[`ERASE_BIT] & erase_setup_q;
      end
    end
  end

  // ****************************************************************
  // Next value of the other registers
  // ****************************************************************
  always @* begin
    power_down_disable_d = power_down_disable_q;
    if (wr_pwr) begin
      power_down_disable_d = wdata_in[`POWER_DOWN_DISABLE_BIT];
    end
  end

  always @* begin
    access_enable_d = access_enable_q;
    if (wr_en) begin
      access_enable_d = wdata_in[`ACCESS_ENABLE_BIT];
    end
  end

  genvar blk;
  generate
    for (blk = 0; blk < 8; blk = blk + 1) begin : g_block
      assign erase_block_d[blk] = wr_block ? wdata_in[blk] :
                                  erase_block_q[blk];
    end
  endgenerate

  // low power only in sub-active with power-down allowed
  always @* begin
    low_power_d = sub_sync2_q & ~power_down_disable_q;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // control one resets to zero
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_write_enable_q <= 1'b0;
      erase_setup_q     <= 1'b0;
      program_setup_q   <= 1'b0;
      erase_verify_q    <= 1'b0;
      program_verify_q  <= 1'b0;
      erase_q           <= 1'b0;
      program_q         <= 1'b0;
    end else begin
      sw_write_enable_q <= sw_write_enable_d;
      erase_setup_q     <= erase_setup_d;
      program_setup_q   <= program_setup_d;
      erase_verify_q    <= erase_verify_d;
      program_verify_q  <= program_verify_d;
      erase_q           <= erase_d;
      program_q         <= program_d;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_down_disable_q <= 1'b0;
      erase_block_q        <= `REG_RESET_VALUE;
      access_enable_q      <= 1'b0;
    end else begin
      power_down_disable_q <= power_down_disable_d;
      erase_block_q        <= erase_block_d;
      access_enable_q      <= access_enable_d;
    end
  end

  // Only the second flop of each pair feeds logic
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_sync1_q  <= 1'b0;
      err_sync2_q  <= 1'b0;
      sub_sync1_q  <= 1'b0;
      sub_sync2_q  <= 1'b0;
      error_flag_q <= 1'b0;
    end else begin
      err_sync1_q  <= flash_error_in;
      err_sync2_q  <= err_sync1_q;
      sub_sync1_q  <= sub_active_in;
      sub_sync2_q  <= sub_sync1_q;
      // flag follows the array, never software
      error_flag_q <= err_sync2_q;
    end
  end

  // ****************************************************************
  // Read views
  // ****************************************************************
  always @* begin
    ctrl_one_view                        = 8'h00;
    ctrl_one_view[`SW_WRITE_ENABLE_BIT] = sw_write_enable_q;
    ctrl_one_view[`ERASE_SETUP_BIT]     = erase_setup_q;
    ctrl_one_view[`PROGRAM_SETUP_BIT]   = program_setup_q;
    ctrl_one_view[`ERASE_VERIFY_BIT]    = erase_verify_q;
    ctrl_one_view[`PROGRAM_VERIFY_BIT]  = program_verify_q;
    ctrl_one_view[`ERASE_BIT]           = erase_q;
    ctrl_one_view[`PROGRAM_BIT]         = program_q;
  end

  always @* begin
    ctrl_two_view                          = 8'h00;
    ctrl_two_view[`FLASH_ERROR_FLAG_BIT]   = error_flag_q;
    power_view                             = 8'h00;
    power_view[`POWER_DOWN_DISABLE_BIT]    = power_down_disable_q;
    enable_view                            = 8'h00;
    enable_view[`ACCESS_ENABLE_BIT]        = access_enable_q;
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // hidden registers read zero
  always @* begin
    rdata_d = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `FLASH_ACCESS_ENABLE_ADDR: begin
          rdata_d = enable_view;
        end
        `FLASH_CONTROL_ONE_ADDR: begin
          if (access_enable_q) begin
            rdata_d = ctrl_one_view;
          end
        end
        `FLASH_CONTROL_TWO_ADDR: begin
          if (access_enable_q) begin
            rdata_d = ctrl_two_view;
          end
        end
        `FLASH_POWER_CONTROL_ADDR: begin
          if (access_enable_q) begin
            rdata_d = power_view;
          end
        end
        `ERASE_BLOCK_SELECT_ADDR: begin
          if (access_enable_q) begin
            rdata_d = erase_block_q;
          end
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out           <= 8'h00;
      sw_write_enable_out <= 1'b0;
      program_mode_out    <= 1'b0;
      erase_mode_out      <= 1'b0;
      program_verify_out  <= 1'b0;
      erase_verify_out    <= 1'b0;
      program_setup_out   <= 1'b0;
      erase_setup_out     <= 1'b0;
      erase_block_out     <= 8'h00;
      flash_low_power_out <= 1'b0;
    end else begin
      rdata_out           <= rdata_d;
      sw_write_enable_out <= sw_write_enable_d;
      program_mode_out    <= program_d;
      erase_mode_out      <= erase_d;
      program_verify_out  <= program_verify_d;
      erase_verify_out    <= erase_verify_d;
      program_setup_out   <= program_setup_d;
      erase_setup_out     <= erase_setup_d;
      erase_block_out     <= erase_block_q;
      flash_low_power_out <= low_power_d;
    end
  end

endmodule // flash_program_erase_control

//--- verif/flash_ctrl_checker_asserts.sv
// Purpose: Port-level checks of the flash program/erase control block.
// Assumes: Register map fixed by the design's map header.
// Notes:   Access enable is internal, so checks look at stored effects.
`timescale 1ns/100ps
module flash_ctrl_checker (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire [15:0] addr_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire        sub_active_in,
  input wire [7:0]  rdata_out,
  input wire        sw_write_enable_out,
  input wire        program_mode_out,
  input wire        erase_mode_out,
  input wire        program_verify_out,
  input wire        erase_verify_out,
  input wire        flash_low_power_out,
  input wire        program_setup_out,
  input wire        erase_setup_out,
  input wire [7:0]  erase_block_out
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_no_read;
    !rd_in ##1 1'b1;
  endsequence
  a_prog_needs_setup: assert property (
    $rose(program_mode_out) |-> $past(program_setup_out) && sw_write_enable_out)
    else $error("program mode without stored setup");
  a_erase_needs_setup: assert property (
    $rose(erase_mode_out) |-> $past(erase_setup_out) && sw_write_enable_out)
    else $error("erase mode without stored setup");
  a_pverify_needs_we: assert property (
    program_verify_out |-> sw_write_enable_out)
    else $error("program verify without write enable");
  a_everify_needs_we: assert property (
    erase_verify_out |-> sw_write_enable_out)
    else $error("erase verify without write enable");
  a_low_power_sub: assert property (
    flash_low_power_out |-> $past(sub_active_in, 3))
    else $error("low power outside sub-active mode");
  a_psetup_needs_we: assert property (
    program_setup_out |-> sw_write_enable_out)
    else $error("program setup without write enable");
  a_esetup_needs_we: assert property (
    erase_setup_out |-> sw_write_enable_out)
    else $error("erase setup without write enable");
  a_we_from_write: assert property (
    $rose(sw_write_enable_out) |-> $past(wr_in) && $past(addr_in) == 16'hf020)
    else $error("write enable rose without a control write");
  a_we_clears_all: assert property (
    $fell(sw_write_enable_out) |-> !program_mode_out && !erase_mode_out &&
      !program_setup_out && !erase_setup_out)
    else $error("mode bits survive loss of write enable");
  a_read_data_idle: assert property (
    s_no_read |-> rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_block_from_write: assert property (
    $changed(erase_block_out) |-> $past(wr_in, 2) &&
      $past(addr_in, 2) == 16'hf023)
    else $error("erase block changed without write");
endmodule // flash_ctrl_checker

bind flash_program_erase_control flash_ctrl_checker flash_ctrl_checker_inst (
  .clk_in, .rst_n_in, .addr_in, .wr_in, .rd_in, .rdata_out,
  .sw_write_enable_out, .program_mode_out, .erase_mode_out,
  .program_verify_out, .program_setup_out, .erase_setup_out, .erase_block_out,
  .sub_active_in, .erase_verify_out, .flash_low_power_out);

//--- verif/testbench.sv
// Purpose: Self-checking bench of the flash program/erase control block.
// Assumes: Read data valid only in the cycle after the read strobe.
// Notes:   Mode outputs are packed like the first control register.
`timescale 1ns/100ps
module testbench;
  reg         clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
  reg         flash_error_in = 0, sub_active_in = 0;
  reg  [15:0] addr_in = 0;
  reg  [7:0]  wdata_in = 0;
  wire [7:0]  rdata_out, erase_block_out, modes;
  wire        sw_write_enable_out, program_mode_out, erase_mode_out;
  wire        program_verify_out, erase_verify_out, program_setup_out;
  wire        erase_setup_out, flash_low_power_out;
  int         failures = 0, compares = 0;
  assign modes = {1'b0, sw_write_enable_out, erase_setup_out,
    program_setup_out, erase_verify_out, program_verify_out,
    erase_mode_out, program_mode_out};
  flash_program_erase_control flash_program_erase_control_inst (
    .clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .flash_error_in, .sub_active_in, .rdata_out, .sw_write_enable_out,
    .program_mode_out, .erase_mode_out, .program_verify_out,
    .erase_verify_out, .program_setup_out, .erase_setup_out,
    .erase_block_out, .flash_low_power_out);
  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk("rdata", e, rdata_out);
  endtask
  task conclude;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_closed;
    chk("modes", 8'h00, modes);
    wr(16'hf020, 8'h40);
    rd(16'hf020, 8'h00);
    chk("modes", 8'h00, modes);
  endtask
  task t_program;
    wr(16'hf02b, 8'h80);
    rd(16'hf02b, 8'h80);
    wr(16'hf020, 8'h51);
    rd(16'hf020, 8'h50);
    wr(16'hf020, 8'h51);
    rd(16'hf020, 8'h51);
    chk("modes", 8'h51, modes);
    wr(16'hf020, 8'h11);
    chk("modes", 8'h00, modes);
  endtask
  task t_erase;
    wr(16'hf020, 8'h60);
    wr(16'hf020, 8'h62);
    rd(16'hf020, 8'h62);
    chk("modes", 8'h62, modes);
    wr(16'hf020, 8'h4c);
    chk("modes", 8'h4c, modes);
    wr(16'hf020, 8'h0c);
    rd(16'hf020, 8'h00);
  endtask
  task t_others;
    wr(16'hf023, 8'ha5);
    rd(16'hf023, 8'ha5);
    chk("blocks", 8'ha5, erase_block_out);
    wr(16'hf023, 8'h00);
    rd(16'hf023, 8'h00);
    rd(16'hf021, 8'h00);
    rd(16'hf024, 8'h00);
    @(posedge clk_in);
    sub_active_in <= 1'b1;
    flash_error_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1 chk("low_power", 8'h01, {7'h00, flash_low_power_out});
    rd(16'hf021, 8'h80);
    wr(16'hf022, 8'h80);
    rd(16'hf022, 8'h80);
    chk("low_power", 8'h00, {7'h00, flash_low_power_out});
    wr(16'hf02b, 8'h00);
    wr(16'hf022, 8'h00);
    rd(16'hf022, 8'h00);
    wr(16'hf02b, 8'h80);
    rd(16'hf022, 8'h80);
  endtask
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    repeat (2000) @(posedge clk_in);
    failures++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_closed;
    t_program;
    t_erase;
    t_others;
    conclude;
  end
endmodule // testbench
